//--- logic/scws_defines.vh
// Constants for the CAS waveform sequencer.
`ifndef SCWS_DEFINES_VH
`define SCWS_DEFINES_VH
`define SCWS_WAVE_BITS 96
`define SCWS_WORD_BITS 32
`define SCWS_IDX_BITS 7
`define SCWS_BEAT_BITS 4
`define SCWS_BURST_DEFAULT 8
`define SCWS_RST_WAVE0 32'hAAAAAA9F
`define SCWS_RST_WAVE1 32'hAAAAAAAA
`define SCWS_RST_WAVE2 32'hAAAAAAAA
`define SCWS_ST_IDLE 2'h0
`define SCWS_ST_RUN 2'h1
`define SCWS_ST_DONE 2'h2
`endif

//--- logic/scws_edge_filter.v
// Reference edge filter that drops odd transitions under a half-rate clock.
`timescale 1ns/1ps
module scws_edge_filter (
	input wire sys_clk,
	input wire rst,
	input wire clk_en,
	input wire start,
	input wire half_rate,
	input wire rise_seen,
	output reg ref_edge
);
	reg phase_reg;

	// Under half rate only every second rising transition counts, so each beat eats two.
	always @(posedge sys_clk) begin
		if (rst) begin
			phase_reg <= 1'b0;
			ref_edge <= 1'b0;
		end else if (clk_en) begin
			if (start) begin
				phase_reg <= 1'b0;
				ref_edge <= 1'b0;
			end else if (rise_seen) begin
				phase_reg <= ~phase_reg;
				ref_edge <= ~half_rate | phase_reg;
			end else begin
				ref_edge <= 1'b0;
			end
		end
	end
endmodule

//--- logic/scws_sequencer.v
// Top of the SDRAM and synchronous ROM CAS waveform sequencer.
`timescale 1ns/1ps
`include "scws_defines.vh"
module scws_sequencer #(
	parameter BURST_LEN = `SCWS_BURST_DEFAULT
) (
	input wire sys_clk,
	input wire rst,
	input wire clk_en,
	input wire [31:0] cas_waveform_rotate0,
	input wire [31:0] cas_waveform_rotate1,
	input wire [31:0] cas_waveform_rotate2,
	input wire access_start,
	input wire access_is_rom,
	input wire [3:0] burst_beats,
	input wire rom_clock_half_rate,
	input wire pair01_clock_half_rate,
	input wire pair23_clock_half_rate,
	input wire bank_pair23,
	output reg row_strobe_or_sync_select_n,
	output reg sync_column_strobe_n,
	output reg latch_ref_edge,
	output reg [6:0] ras_cas_ones,
	output reg delayed_latch,
	output reg busy,
	output reg wave_error
);
	// ----------------------------------------
	// Waveform assembly and static decode
	// ----------------------------------------
	wire [95:0] wave;
	wire half_rate;
	reg [6:0] lead_cnt;
	reg [1:0] gap_cnt;
	reg run_ok;
	reg in_gap;
	integer i;

	// The third word sits above the second, the second above the first.
	assign wave = {cas_waveform_rotate2, cas_waveform_rotate1, cas_waveform_rotate0};
	assign half_rate = access_is_rom ? rom_clock_half_rate :
		(bank_pair23 ? pair23_clock_half_rate : pair01_clock_half_rate);

	// Count leading ones and the zeros that follow before the next one.
	always @* begin
		lead_cnt = 7'h00;
		gap_cnt = 2'h0;
		run_ok = 1'b1;
		in_gap = 1'b0;
		for (i = 0; i < `SCWS_WAVE_BITS; i = i + 1) begin
			if (run_ok && !in_gap && wave[i]) begin
				lead_cnt = lead_cnt + 7'h01;
			end else if (run_ok && !wave[i]) begin
				in_gap = 1'b1;
				if (gap_cnt != 2'h3) begin
					gap_cnt = gap_cnt + 2'h1;
				end
			end else if (run_ok && in_gap && wave[i]) begin
				run_ok = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Walk through the waveform
	// ----------------------------------------
	// State codes; DONE costs one cycle so the row strobe, and for SDRAM the column strobe, rise in the same cycle that busy falls.
	localparam [1:0] ST_IDLE = `SCWS_ST_IDLE;
	localparam [1:0] ST_RUN = `SCWS_ST_RUN;
	localparam [1:0] ST_DONE = `SCWS_ST_DONE;
	reg [1:0] state_reg;
	reg cas_started_reg;
	reg [6:0] idx_reg;
	reg prev_bit_reg;
	reg [4:0] beat_reg;
	reg first_col_reg;
	reg rom_reg;
	reg [4:0] beat_target;
	wire cur_bit;
	wire rise_seen;
	wire ref_edge;

	assign cur_bit = wave[idx_reg];
	// Only rising transitions after the strobe has first asserted are references.
	// A ROM strobe is back high one cycle after it falls, so a flag and not the pin gates them.
	assign rise_seen = (state_reg == ST_RUN) && cas_started_reg && cur_bit && !prev_bit_reg;

	always @* begin
		beat_target = (burst_beats == 4'h0) ? BURST_LEN[4:0] : {1'b0, burst_beats};
	end

	// The filter adds one register stage, so a beat is counted one cycle after its rise.
	// The filter phase restarts with every access so the first rise is always the odd one.
	scws_edge_filter u_filter (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.start(access_start && state_reg == ST_IDLE),
		.half_rate(half_rate),
		.rise_seen(rise_seen),
		.ref_edge(ref_edge)
	);

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	// Row strobe first, bit zero goes out one cycle later.
	// The waveform inputs must stay put for the whole access; they are read live, not copied.
	always @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			idx_reg <= 7'h00;
			prev_bit_reg <= 1'b1;
			beat_reg <= 5'h00;
			first_col_reg <= 1'b0;
			rom_reg <= 1'b0;
			cas_started_reg <= 1'b0;
			row_strobe_or_sync_select_n <= 1'b1;
			sync_column_strobe_n <= 1'b1;
			latch_ref_edge <= 1'b0;
			ras_cas_ones <= 7'h00;
			delayed_latch <= 1'b0;
			busy <= 1'b0;
			wave_error <= 1'b0;
		end else if (clk_en) begin
			latch_ref_edge <= ref_edge;
			case (state_reg)
				ST_IDLE: begin
					sync_column_strobe_n <= 1'b1;
					if (access_start) begin
						row_strobe_or_sync_select_n <= 1'b0;
						state_reg <= ST_RUN;
						cas_started_reg <= 1'b0;
						idx_reg <= 7'h00;
						prev_bit_reg <= 1'b1;
						beat_reg <= 5'h00;
						first_col_reg <= 1'b1;
						rom_reg <= access_is_rom;
						busy <= 1'b1;
						ras_cas_ones <= lead_cnt;
						// Two zeros mean delayed latching, dropped under half rate.
						delayed_latch <= (gap_cnt == 2'h2) && !half_rate;
						wave_error <= (gap_cnt == 2'h0) || (gap_cnt == 2'h3) || (lead_cnt == 7'h00);
					end
				end
				ST_RUN: begin
					prev_bit_reg <= cur_bit;
					// Wrap at the top bit; a full pattern never needs it for eight beats.
					idx_reg <= (idx_reg == 7'd95) ? 7'h00 : idx_reg + 7'h01;
					if (sync_column_strobe_n && first_col_reg && prev_bit_reg && !cur_bit) begin
						sync_column_strobe_n <= 1'b0;
						// Remembered apart from the pin, which a ROM access raises again at once.
						cas_started_reg <= 1'b1;
					end else if (!sync_column_strobe_n && first_col_reg) begin
						first_col_reg <= 1'b0;
						if (rom_reg) begin
							sync_column_strobe_n <= 1'b1;
						end
					end
					if (ref_edge) begin
						// SDRAM strobe stays low until the last beat is latched.
						beat_reg <= beat_reg + 5'h01;
						if (beat_reg + 5'h01 >= beat_target) begin
							state_reg <= ST_DONE;
						end
					end
				end
				// The last latch pulse is still out while busy is high in this cycle.
				ST_DONE: begin
					sync_column_strobe_n <= 1'b1;
					row_strobe_or_sync_select_n <= 1'b1;
					busy <= 1'b0;
					cas_started_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
				// An unused code falls back to idle; only the column strobe is raised there next cycle.
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

//--- testbench/scws_checker.sv
// Port timing checker of the CAS waveform sequencer.
`timescale 1ns/1ps
module scws_chk(input wire sys_clk, input wire rst, input wire access_start, input wire access_is_rom,
	input wire bank_pair23, input wire rom_clock_half_rate, input wire pair01_clock_half_rate,
	input wire pair23_clock_half_rate, input wire row_strobe_or_sync_select_n,
	input wire sync_column_strobe_n, input wire latch_ref_edge, input wire [6:0] ras_cas_ones,
	input wire delayed_latch, input wire busy);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Short aliases, plus the half-rate setting of whichever memory is addressed.
	wire rn = row_strobe_or_sync_select_n;
	wire cn = sync_column_strobe_n;
	wire le = latch_ref_edge;
	wire h = access_is_rom ? rom_clock_half_rate : bank_pair23 ? pair23_clock_half_rate : pair01_clock_half_rate;
	start_row_a: assert property (!busy && !$past(busy) && access_start |=> !rn && busy) else $error("no start");
	idle_high_a: assert property (!busy |-> rn && cn) else $error("strobe idle");
	rom_pulse_a: assert property (access_is_rom && $fell(cn) |=> cn) else $error("rom width");
	sd_hold_a: assert property (!access_is_rom && $rose(cn) |-> ##[0:1] !busy) else $error("sd hold");
	half_dl_a: assert property (busy && h |-> !delayed_latch) else $error("dl half");
	edge_busy_a: assert property (le |-> busy) else $error("edge idle");
	half_gap_a: assert property (h && le |=> !le [*3]) else $error("half gap");
	ones_hold_a: assert property (busy && $past(busy) |-> $stable(ras_cas_ones)) else $error("ones");
	cover property (access_is_rom && $fell(cn));
	cover property (h && le);
	cover property (delayed_latch && busy);
endmodule
bind scws_sequencer scws_chk scws_chk_i(.*);

//--- testbench/scws_mem.sv
// Memory-side model that counts latched beats of a burst.
`timescale 1ns/1ps
module scws_mem(input wire sys_clk, input wire row_n, input wire edge_in, output integer beats);
	reg row_q = 1;
	// A new row open clears the count, so it stays readable after the burst.
	always @(posedge sys_clk) begin
		row_q <= row_n;
		if (!row_n && row_q) beats <= 0;
		else if (edge_in) beats <= beats + 1;
	end
endmodule

//--- testbench/scws_sequencer_bench.sv
// Self-checking bench of the CAS waveform sequencer.
`timescale 1ns/1ps
module scws_sequencer_bench;
	reg sys_clk = 0, rst = 1, st = 0, rom = 0, bk = 0, h0 = 0, h1 = 0, h2 = 0;
	reg [95:0] w = 0;
	reg [3:0] bb = 0;
	wire rn, cn, le, dl, bsy, err;
	wire [6:0] ones;
	wire [31:0] beats;
	integer i, seed = 32'h7A50, num_errors = 0, cmp_count = 0, cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	scws_sequencer scws_sequencer_i(.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .cas_waveform_rotate0(w[31:0]),
		.cas_waveform_rotate1(w[63:32]), .cas_waveform_rotate2(w[95:64]), .access_start(st), .access_is_rom(rom),
		.burst_beats(bb), .rom_clock_half_rate(h0), .pair01_clock_half_rate(h1), .pair23_clock_half_rate(h2),
		.bank_pair23(bk), .row_strobe_or_sync_select_n(rn), .sync_column_strobe_n(cn), .latch_ref_edge(le),
		.ras_cas_ones(ones), .delayed_latch(dl), .busy(bsy), .wave_error(err));
	scws_mem scws_mem_i(.sys_clk(sys_clk), .row_n(rn), .edge_in(le), .beats(beats));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d errors %0d", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask
	// A hung handshake is cut short well past the longest expected run.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	// One random legal access, predicted from the waveform it is given.
	task run(input integer t);
		integer k, g, n, c, hr, j;
		reg [95:0] v;
		begin
			c = $random(seed);
			hr = c[0] ? c[2] : c[1] ? c[4] : c[3];
			n = {$random(seed)} % 3;
			k = hr ? 3 + 4 * n : 3 + 2 * n;
			g = 1 + c[5];
			for (j = 0; j < 96; j = j + 1) v[j] = j < k || (j >= k + g && (j - k - g) % 2 == 0);
			n = c[8:6];
			@(posedge sys_clk);
			rom <= c[0]; // Only synchronous memories share the waveform here.
			bk <= c[1];
			h0 <= c[2];
			h1 <= c[3];
			h2 <= c[4];
			bb <= {1'b0, c[8:6]};
			w <= v;
			st <= 1;
			@(posedge sys_clk);
			st <= 0;
			c = 0;
			while (rn !== 1'b0 && c < 9) begin @(posedge sys_clk); #1 c = c + 1; end
			c = 0;
			while (cn !== 1'b0 && c < 99) begin @(posedge sys_clk); #1 c = c + 1; end
			// The wait above ends one cycle after the row strobe fell, so that cycle is added back.
			chk(c + 1, k + 1);
			chk(32'(ones), k);
			chk(32'(dl), g == 2 && !hr);
			chk(32'(err), 0);
			c = 0;
			while (bsy !== 1'b0 && c < 300) begin @(posedge sys_clk); #1 c = c + 1; end
			chk(beats, n == 0 ? 8 : n);
			$display("test %0d done", t);
		end
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		for (i = 0; i < 40; i = i + 1) run(i);
		wrap_up;
	end
endmodule
